/* dacus_defines.svh */
// timing-free constants and field positions for the converter update scheduler
`ifndef DACUS_DEFINES_SVH
`define DACUS_DEFINES_SVH
`define DACUS_CTRL_RESET     8'h00
`define DACUS_CTRL_ON_BIT    7
`define DACUS_CTRL_SRC_HI    4
`define DACUS_CTRL_SRC_LO    3
`define DACUS_CTRL_USED_MASK 8'h9f
`define DACUS_DATA_RESET     8'h00
`define DACUS_CODE_RESET     12'h000
`define DACUS_CODE_WIDTH     12
`define DACUS_CHANNELS       2
`endif

/* dacus_pkg.sv */
// types shared by the converter update scheduler
package dacus_pkg;
    typedef enum logic [1:0] {
        DACUS_SRC_WRITE,
        DACUS_SRC_TIMER3,
        DACUS_SRC_TIMER4,
        DACUS_SRC_TIMER2
    } dacus_src_t;
endpackage

/* dacus_chan_if.sv */
// per-channel signals between the scheduler top and one channel
`timescale 1ns/10ps
interface dacus_chan_if;
    logic [7:0]  ctrl_wdata;
    logic        ctrl_we;
    logic [7:0]  low_wdata;
    logic        low_we;
    logic [7:0]  high_wdata;
    logic        high_we;
    logic        tmr2_ovf;
    logic        tmr3_ovf;
    logic        tmr4_ovf;
    logic [7:0]  ctrl_rd;
    logic [7:0]  low_rd;
    logic [7:0]  high_rd;
    logic [11:0] code;
    logic        on;
    modport top  (output ctrl_wdata, ctrl_we, low_wdata, low_we, high_wdata, high_we,
                  tmr2_ovf, tmr3_ovf, tmr4_ovf,
                  input ctrl_rd, low_rd, high_rd, code, on);
    modport chan (input ctrl_wdata, ctrl_we, low_wdata, low_we, high_wdata, high_we,
                  tmr2_ovf, tmr3_ovf, tmr4_ovf,
                  output ctrl_rd, low_rd, high_rd, code, on);
endinterface

/* dacus_chan.sv */
// one converter channel: control, held data bytes and input latch
`timescale 1ns/10ps
`include "dacus_defines.svh"
module dacus_chan
    import dacus_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic clk_en,
    // channel signals
    dacus_chan_if.chan ch
);
    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  low_reg, low_next;
    logic [7:0]  high_reg, high_next;
    logic [11:0] code_reg, code_next;
    logic        xfer_reg, xfer_next;
    dacus_src_t  src;

    assign src = dacus_src_t'(ctrl_reg[`DACUS_CTRL_SRC_HI:`DACUS_CTRL_SRC_LO]);

    always_comb begin
        ctrl_next = ctrl_reg;
        low_next  = low_reg;
        high_next = high_reg;
        code_next = code_reg;
        xfer_next = 1'b0;
        if (ch.ctrl_we) begin
            ctrl_next = ch.ctrl_wdata & `DACUS_CTRL_USED_MASK;
        end
        // low byte is only buffered, never moves the output by itself
        if (ch.low_we) begin
            low_next = ch.low_wdata;
        end
        if (ch.high_we) begin
            high_next = ch.high_wdata;
        end
        // timer strobe is marked now, latch copies one cycle later
        unique case (src)
            DACUS_SRC_WRITE:  xfer_next = ch.high_we;
            DACUS_SRC_TIMER3: xfer_next = ch.tmr3_ovf;
            DACUS_SRC_TIMER4: xfer_next = ch.tmr4_ovf;
            DACUS_SRC_TIMER2: xfer_next = ch.tmr2_ovf;
        endcase
        // whole word in one step, low byte in the low eight bits
        if (xfer_reg) begin
            code_next = {high_reg[3:0], low_reg};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_reg <= `DACUS_CTRL_RESET;
            low_reg  <= `DACUS_DATA_RESET;
            high_reg <= `DACUS_DATA_RESET;
            code_reg <= `DACUS_CODE_RESET;
            xfer_reg <= 1'b0;
        end else if (clk_en) begin
            ctrl_reg <= ctrl_next;
            low_reg  <= low_next;
            high_reg <= high_next;
            code_reg <= code_next;
            xfer_reg <= xfer_next;
        end
    end

    assign ch.ctrl_rd = ctrl_reg;
    assign ch.low_rd  = low_reg;
    assign ch.high_rd = high_reg;
    assign ch.code    = code_reg;
    assign ch.on      = ctrl_reg[`DACUS_CTRL_ON_BIT];
endmodule

/* dacus_top.sv */
// update scheduler for two 12-bit converter channels
`timescale 1ns/10ps
`include "dacus_defines.svh"
module dacus_top
    import dacus_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // register writes, one strobe per register and channel
    input  wire logic [1:0]  ctrl_we,
    input  wire logic [1:0]  low_we,
    input  wire logic [1:0]  high_we,
    input  wire logic [7:0]  wdata,
    // timer overflow strobes, same clock
    input  wire logic        tmr2_ovf,
    input  wire logic        tmr3_ovf,
    input  wire logic        tmr4_ovf,
    // register readback
    output logic      [15:0] ctrl_rd,
    output logic      [15:0] low_rd,
    output logic      [15:0] high_rd,
    // converter side
    output logic      [23:0] conv_code,
    output logic      [1:0]  conv_on,
    output logic      [1:0]  conv_out_oe
);
    logic [15:0] ctrl_rd_next, low_rd_next, high_rd_next;
    logic [23:0] code_next;
    logic [1:0]  on_next;
    logic [7:0]  c_rd [2];
    logic [7:0]  l_rd [2];
    logic [7:0]  h_rd [2];
    logic [11:0] c_code [2];
    logic [1:0]  c_on;

    genvar g;
    generate
        for (g = 0; g < `DACUS_CHANNELS; g = g + 1) begin : gen_chan
            dacus_chan_if cif ();
            assign cif.ctrl_wdata = wdata;
            assign cif.ctrl_we    = ctrl_we[g];
            assign cif.low_wdata  = wdata;
            assign cif.low_we     = low_we[g];
            assign cif.high_wdata = wdata;
            assign cif.high_we    = high_we[g];
            assign cif.tmr2_ovf   = tmr2_ovf;
            assign cif.tmr3_ovf   = tmr3_ovf;
            assign cif.tmr4_ovf   = tmr4_ovf;
            assign c_rd[g]        = cif.ctrl_rd;
            assign l_rd[g]        = cif.low_rd;
            assign h_rd[g]        = cif.high_rd;
            assign c_code[g]      = cif.code;
            assign c_on[g]        = cif.on;
            // independent state per channel
            dacus_chan u_chan (
                .clk_sys (clk_sys),
                .reset   (reset),
                .clk_en  (clk_en),
                .ch      (cif.chan)
            );
        end
    endgenerate

    always_comb begin
        ctrl_rd_next = {c_rd[1], c_rd[0]};
        low_rd_next  = {l_rd[1], l_rd[0]};
        high_rd_next = {h_rd[1], h_rd[0]};
        code_next    = {c_code[1], c_code[0]};
        on_next      = c_on;
    end

    // registered for clean outputs; adds one cycle of view latency
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_rd     <= {2{`DACUS_CTRL_RESET}};
            low_rd      <= {2{`DACUS_DATA_RESET}};
            high_rd     <= {2{`DACUS_DATA_RESET}};
            conv_code   <= {2{`DACUS_CODE_RESET}};
            conv_on     <= 2'h0;
            conv_out_oe <= 2'h0;
        end else if (clk_en) begin
            ctrl_rd     <= ctrl_rd_next;
            low_rd      <= low_rd_next;
            high_rd     <= high_rd_next;
            conv_code   <= code_next;
            conv_on     <= on_next;
            conv_out_oe <= on_next;
        end
    end
endmodule

/* dacus_props.sv */
// checker for the converter update scheduler
`timescale 1ns/10ps
module dacus_props (
    // stimulus
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic [1:0]  high_we,
    input wire logic [7:0]  wdata,
    input wire logic        tmr2_ovf,
    input wire logic        tmr3_ovf,
    input wire logic        tmr4_ovf,
    // results
    input wire logic [15:0] ctrl_rd,
    input wire logic [15:0] low_rd,
    input wire logic [15:0] high_rd,
    input wire logic [23:0] conv_code,
    input wire logic [1:0]  conv_on,
    input wire logic [1:0]  conv_out_oe
);
    // readback source lags the internal one, so scenarios leave gaps after a mode change
    wire       nt   = !tmr2_ovf && !tmr3_ovf && !tmr4_ovf;
    wire [1:0] src0 = ctrl_rd[4:3];
    default clocking @(posedge clk_sys); endclocking
    // frozen cycles stretch every latency, so those attempts are dropped
    default disable iff (reset || !clk_en);
    AST_OE_IS_ON: assert property (conv_out_oe == conv_on && conv_on == {ctrl_rd[15], ctrl_rd[7]})
        else $error("oe differs from on");
    AST_FREEZE: assert property (disable iff (reset) !clk_en |=> $stable(conv_code) && $stable(conv_on)
        && $stable(ctrl_rd) && $stable(low_rd) && $stable(high_rd)) else $error("state moved while frozen");
    AST_UNUSED_ZERO: assert property (ctrl_rd[6:5] == 2'h0 && ctrl_rd[14:13] == 2'h0)
        else $error("unused bits set");
    AST_HOLD: assert property (high_we == 2'h0 && nt |=> ##2 $stable(conv_code))
        else $error("code moved untriggered");
    AST_XFER0: assert property (src0 == 2'h0 && high_we[0] |-> ##3
        conv_code[11:8] == $past(wdata[3:0], 3)) else $error("ch0 write transfer");
    AST_XFER1: assert property (ctrl_rd[12:11] == 2'h0 && high_we[1] |-> ##3
        conv_code[23:20] == $past(wdata[3:0], 3)) else $error("ch1 write transfer");
    AST_TMR: assert property (src0 == 2'h1 && tmr3_ovf |-> ##3
        conv_code[11:0] == $past({high_rd[3:0], low_rd[7:0]}, 3)) else $error("timer transfer");
    AST_TMODE: assert property (src0 != 2'h0 && high_we[0] && nt |=> ##2 $stable(conv_code[11:0]))
        else $error("high write in timer mode");
    AST_WRONG: assert property (src0 == 2'h1 && !tmr3_ovf && !high_we[0] |=> ##2 $stable(conv_code[11:0]))
        else $error("wrong timer moved code");
    cover property (src0 == 2'h1 && tmr3_ovf);
    cover property (src0 == 2'h0 && high_we[0]);
    cover property (conv_on == 2'h2);
    cover property (disable iff (reset) !clk_en && high_we[0]);
endmodule
bind dacus_top dacus_props u_props (.*);

/* dac_update_scheduler_bench.sv */
// self-checking bench for the converter update scheduler
`timescale 1ns/10ps
module dac_update_scheduler_bench;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        clk_en  = 1'b1;
    logic [1:0]  ctrl_we = 2'h0, low_we = 2'h0, high_we = 2'h0;
    logic [7:0]  wdata   = 8'h00;
    logic        tmr2_ovf = 1'b0, tmr3_ovf = 1'b0, tmr4_ovf = 1'b0;
    logic [15:0] ctrl_rd, low_rd, high_rd;
    logic [23:0] conv_code;
    logic [1:0]  conv_on, conv_out_oe;
    logic [11:0] old;
    int          failures = 0, checks_done = 0;
    dacus_top DUT (.*);
    initial forever #5 clk_sys = ~clk_sys;
    // one strobe cycle, then wait past the three-edge latch delay
    task automatic wr(input logic [8:0] m, input logic [7:0] d);
        @(posedge clk_sys);
        wdata <= d;
        {tmr4_ovf, tmr3_ovf, tmr2_ovf, high_we, low_we, ctrl_we} <= m;
        @(posedge clk_sys);
        {tmr4_ovf, tmr3_ovf, tmr2_ovf, high_we, low_we, ctrl_we} <= 9'h000;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic t_demand;
        chk("code", 24'h000000, conv_code);
        wr(9'h001, 8'he7);
        chk("ctrl", 24'h000087, {16'h0, ctrl_rd[7:0]});
        chk("on", 24'h000005, {20'h0, conv_on, conv_out_oe});
        wr(9'h004, 8'hff);
        chk("code", 24'h000000, conv_code);
        wr(9'h010, 8'h0f);
        chk("code", 24'h000fff, conv_code);
        wr(9'h002, 8'h80);
        wr(9'h008, 8'h00);
        wr(9'h020, 8'h35);
        chk("code", 24'h500fff, conv_code);
        chk("ctrl", 24'h008087, {8'h00, ctrl_rd});
        chk("low", 24'h0000ff, {8'h00, low_rd});
        chk("high", 24'h00350f, {8'h00, high_rd});
        $display("demand test done");
    endtask
    task automatic t_timer;
        logic [2:0]  t;
        logic [11:0] e;
        for (logic [2:0] s = 3'h1; s < 3'h4; s++) begin
            t = (s == 3'h1) ? 3'h2 : (s == 3'h2) ? 3'h4 : 3'h1;
            e = 12'h040 + 12'h101 * s;
            wr(9'h001, {1'b1, 2'h0, s[1:0], 3'h0});
            wr(9'h004, 8'h40 + s);
            wr(9'h010, 8'hf0 + s);
            chk("code", {12'h500, old}, conv_code);
            wr({t ^ 3'h7, 6'h00}, 8'h00);
            chk("code", {12'h500, old}, conv_code);
            wr({t, 6'h00}, 8'h00);
            chk("code", {12'h500, e}, conv_code);
            old = e;
        end
        wr(9'h001, 8'h00);
        chk("on", 24'h00000a, {20'h0, conv_on, conv_out_oe});
        $display("timer test done");
    endtask
    // strobes with the enable low are lost, then a mid-run reset
    task automatic t_freeze;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(9'h014, 8'h07);
        chk("frozen high", 24'h0035f3, {8'h00, high_rd});
        chk("frozen code", 24'h500343, conv_code);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        wr(9'h010, 8'h07);
        chk("resumed", 24'h500743, conv_code);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("reset code", 24'h000000, conv_code);
        chk("reset regs", 24'h000000, {ctrl_rd | low_rd | high_rd, 4'h0, conv_on, conv_out_oe});
        wr(9'h010, 8'h0a);
        chk("code", 24'h000a00, conv_code);
        $display("freeze and reset test done");
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        t_demand;
        old = 12'hfff;
        t_timer;
        t_freeze;
        test_done;
    end
    initial begin
        repeat (1000) @(posedge clk_sys);
        failures++;
        test_done;
    end
endmodule
